// >>> ktm_keepalive_timer_int_map.sv
// Contract
// - Wake code 00 is 80 ms, 01 160 ms
// - Wake code 10 is 320 ms, 11 640 ms
// - Keep-alive code zero disables timer, no expiry
// - Codes 1 to 11 double from 160 ms
// - Codes 12 to 20 keep doubling to hours
// - Each expiry sets heartbeat status bit four
// - Reading second status clears heartbeat bit
// - Heartbeat status routable to either interrupt pin; only pin one is built here
// - Timer control resets to zero
// - Map bit 7 routes trim load error
// - Map bit 6 routes config error
// - Map bit 4 routes heartbeat expiry
// - Map bit 3 routes aux high event
// - Map bit 2 routes aux low event
// - Map bit 1 routes double knock
// - Map bit 0 routes single knock
// - Pin one upper map resets to zero
`timescale 1ns/10ps
module ktm_keepalive_timer_int_map #(
    parameter int unsigned TICK_CYCLES = ktm_pkg::TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [ktm_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [ktm_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_rd,
    output logic [ktm_pkg::DATA_W-1:0] reg_rdata_ff,
    input wire logic trim_load_error,
    input wire logic config_error,
    input wire logic aux_high,
    input wire logic aux_low,
    input wire logic double_knock,
    input wire logic single_knock,
    output logic wake_sample_ff,
    output logic heartbeat_status_ff,
    output logic irq_pin_one_ff
);
    localparam int unsigned PW = ktm_pkg::PRE_W;
    localparam int unsigned WW = ktm_pkg::WAKE_CNT_W;
    localparam int unsigned KW = ktm_pkg::KA_CNT_W;

    logic [7:0] timer_control_ff;
    logic [7:0] int_pin1_upper_source_map_ff;
    logic [PW-1:0] pre_cnt_ff;
    logic tick_ff;
    logic [1:0] wake_interval_sel;
    logic [4:0] ka_code;
    logic ka_run;
    logic wr_timer;
    logic wr_map;
    logic rd_status;
    logic [WW-1:0] wake_limit;
    logic [KW-1:0] ka_limit;
    logic wake_expire;
    logic ka_expire;
    logic [7:0] irq_sources;
    logic [7:0] nxt_rdata;

    // Prescaler limit must fit its counter, refused at elaboration
    if (TICK_CYCLES < 1 || TICK_CYCLES >= (1 << PW))
    begin : g_bad_tick
        $error("ktm_keepalive_timer_int_map: TICK_CYCLES out of range");
    end

    // Register access decode
    assign wr_timer = reg_wr && (reg_addr == ktm_pkg::TIMER_CONTROL_OFS);
    assign wr_map = reg_wr && (reg_addr == ktm_pkg::MAP1_UPPER_OFS);
    assign rd_status = reg_rd && (reg_addr == ktm_pkg::SECOND_STATUS_OFS);

    // Field views of timer control
    assign wake_interval_sel = timer_control_ff[ktm_pkg::WAKE_MSB:ktm_pkg::WAKE_LSB];
    assign ka_code = timer_control_ff[ktm_pkg::KA_MSB:ktm_pkg::KA_LSB];

    // Undefined codes behave like off rather than a wrapped span
    assign ka_run = (ka_code != ktm_pkg::KA_OFF_CODE)
        && (ka_code <= ktm_pkg::KA_MAX_CODE);

    // Spans in 80 ms ticks: 1, 2, 4 or 8
    assign wake_limit = WW'(1) << wake_interval_sel;

    // Keep-alive span doubles per code, code 1 is two ticks
    assign ka_limit = KW'(1) << ka_code;

    // Timer control, reserved bit 5 kept as written
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            timer_control_ff <= ktm_pkg::TIMER_CONTROL_RST;
        end
        else if (clk_en && wr_timer)
        begin
            timer_control_ff <= reg_wdata;
        end
    end

    // Pin one upper map, reserved bit 5 stays zero
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            int_pin1_upper_source_map_ff <= ktm_pkg::MAP1_UPPER_RST;
        end
        else if (clk_en && wr_map)
        begin
            int_pin1_upper_source_map_ff <= reg_wdata & ktm_pkg::MAP1_WMASK;
        end
    end

    // Shared 80 ms prescaler; one divider serves both timers to save area
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pre_cnt_ff <= '0;
            tick_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            if (pre_cnt_ff == PW'(TICK_CYCLES - 1))
            begin
                pre_cnt_ff <= '0;
                tick_ff <= 1'b1;
            end
            else
            begin
                pre_cnt_ff <= pre_cnt_ff + PW'(1);
                tick_ff <= 1'b0;
            end
        end
    end

    // Wake-up sample interval
    ktm_span_counter #(
        .CNT_W(WW)
    ) u_wake_cnt (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .tick(tick_ff),
        .run(1'b1),
        .restart(wr_timer),
        .limit(wake_limit),
        .expire_ff(wake_expire)
    );

    // Keep-alive timer, restarted by any timer control write
    ktm_span_counter #(
        .CNT_W(KW)
    ) u_ka_cnt (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .tick(tick_ff),
        .run(ka_run),
        .restart(wr_timer),
        .limit(ka_limit),
        .expire_ff(ka_expire)
    );

    // Wake pulse registered for the outside sampler
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wake_sample_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            wake_sample_ff <= wake_expire;
        end
    end

    // Sticky heartbeat status; a new expiry beats a clearing read
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            heartbeat_status_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            if (ka_expire)
            begin
                heartbeat_status_ff <= 1'b1;
            end
            else if (rd_status)
            begin
                heartbeat_status_ff <= 1'b0;
            end
        end
    end

    // Read data mux, unmapped addresses read zero
    always_comb
    begin
        nxt_rdata = 8'h00;
        case (reg_addr)
            ktm_pkg::TIMER_CONTROL_OFS: nxt_rdata = timer_control_ff;
            ktm_pkg::MAP1_UPPER_OFS: nxt_rdata = int_pin1_upper_source_map_ff;
            ktm_pkg::SECOND_STATUS_OFS:
                nxt_rdata[ktm_pkg::HB_STATUS_BIT] = heartbeat_status_ff;
            default: nxt_rdata = 8'h00;
        endcase
    end

    // Read data captured on the read strobe, held until the next one
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata_ff <= 8'h00;
        end
        else if (clk_en && reg_rd)
        begin
            reg_rdata_ff <= nxt_rdata;
        end
    end

    // Source vector lined up with map bit positions
    always_comb
    begin
        irq_sources = 8'h00;
        irq_sources[ktm_pkg::MAP_TRIM_BIT] = trim_load_error;
        irq_sources[ktm_pkg::MAP_CFG_BIT] = config_error;
        irq_sources[ktm_pkg::MAP_HB_BIT] = heartbeat_status_ff;
        irq_sources[ktm_pkg::MAP_HIGH_BIT] = aux_high;
        irq_sources[ktm_pkg::MAP_LOW_BIT] = aux_low;
        irq_sources[ktm_pkg::MAP_DBL_BIT] = double_knock;
        irq_sources[ktm_pkg::MAP_SGL_BIT] = single_knock;
    end

    // Pin one level, one cycle behind its sources
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_pin_one_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            irq_pin_one_ff <= |(irq_sources & int_pin1_upper_source_map_ff);
        end
    end

    // Helper: ticks seen since the last wake and keep-alive pulses
    logic [WW:0] wake_seen_ff;
    logic [KW:0] ka_seen_ff;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wake_seen_ff <= '0;
            ka_seen_ff <= '0;
        end
        else if (clk_en)
        begin
            if (wr_timer || wake_expire)
            begin
                wake_seen_ff <= '0;
            end
            else if (tick_ff)
            begin
                wake_seen_ff <= wake_seen_ff + (WW+1)'(1);
            end
            if (wr_timer || ka_expire || !ka_run)
            begin
                ka_seen_ff <= '0;
            end
            else if (tick_ff)
            begin
                ka_seen_ff <= ka_seen_ff + (KW+1)'(1);
            end
        end
    end

    a_wake_short_span: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && wake_expire && wake_interval_sel[1] == 1'b0
        |-> wake_seen_ff == ((WW+1)'(1) << wake_interval_sel))
        else $error("wake pulse spacing wrong for short interval");

    a_wake_long_span: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && wake_expire && wake_interval_sel[1] == 1'b1
        |-> wake_seen_ff == ((WW+1)'(1) << wake_interval_sel))
        else $error("wake pulse spacing wrong for long interval");

    a_keep_off_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ka_code == ktm_pkg::KA_OFF_CODE && !$past(wr_timer) |-> !ka_expire)
        else $error("keep-alive expired while off");

    a_keep_span_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ka_expire && ka_code <= 5'h0b |-> ka_seen_ff == ((KW+1)'(1) << ka_code))
        else $error("keep-alive span wrong for low code");

    a_keep_span_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ka_expire && ka_code > 5'h0b |-> ka_seen_ff == ((KW+1)'(1) << ka_code))
        else $error("keep-alive span wrong for high code");

    a_status_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && ka_expire |=> heartbeat_status_ff)
        else $error("heartbeat status not set by expiry");

    a_status_read_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && rd_status && !ka_expire && heartbeat_status_ff
        |=> !heartbeat_status_ff && reg_rdata_ff[ktm_pkg::HB_STATUS_BIT])
        else $error("status read did not return then clear heartbeat");

    a_undef_code_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ka_code > ktm_pkg::KA_MAX_CODE && !$past(wr_timer) |-> !ka_expire)
        else $error("keep-alive expired for undefined code");

    a_irq_or_map: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en |=> irq_pin_one_ff == |($past(irq_sources & int_pin1_upper_source_map_ff)))
        else $error("pin one does not follow mapped sources");

    a_map_blocks_hb: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && int_pin1_upper_source_map_ff == 8'h00 |=> !irq_pin_one_ff)
        else $error("pin one asserted with empty map");

    a_map_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        int_pin1_upper_source_map_ff[5] == 1'b0)
        else $error("reserved map bit became set");

    a_timer_reset_zero: assert property (@(posedge ref_clk)
        $rose(rst_n) |-> timer_control_ff == ktm_pkg::TIMER_CONTROL_RST)
        else $error("timer control not zero after reset");

    a_map_reset_zero: assert property (@(posedge ref_clk)
        $rose(rst_n) |-> int_pin1_upper_source_map_ff == ktm_pkg::MAP1_UPPER_RST)
        else $error("pin one map not zero after reset");

    a_status_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && heartbeat_status_ff && !rd_status |=> heartbeat_status_ff)
        else $error("heartbeat status dropped without a read");

    a_hb_routes_pin: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && heartbeat_status_ff && int_pin1_upper_source_map_ff[ktm_pkg::MAP_HB_BIT]
        |=> irq_pin_one_ff)
        else $error("mapped heartbeat did not reach pin one");

    a_trim_routes_pin: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && trim_load_error && int_pin1_upper_source_map_ff[ktm_pkg::MAP_TRIM_BIT]
        |=> irq_pin_one_ff)
        else $error("mapped trim error did not reach pin one");
endmodule // ktm_keepalive_timer_int_map

// >>> ktm_pkg.sv
package ktm_pkg;
    // Clock and time base
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned TICK_MS = 80;
    localparam int unsigned TICK_CYCLES = TICK_MS * (CLK_HZ / 1000);
    localparam int unsigned PRE_W = 24;

    // Register bus widths
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // Register offsets
    localparam logic [7:0] TIMER_CONTROL_OFS = 8'h39;
    localparam logic [7:0] MAP1_UPPER_OFS = 8'h3a;
    localparam logic [7:0] SECOND_STATUS_OFS = 8'h0c;

    // Reset values
    localparam logic [7:0] TIMER_CONTROL_RST = 8'h00;
    localparam logic [7:0] MAP1_UPPER_RST = 8'h00;

    // Timer control fields
    localparam int unsigned WAKE_MSB = 7;
    localparam int unsigned WAKE_LSB = 6;
    localparam int unsigned KA_MSB = 4;
    localparam int unsigned KA_LSB = 0;
    localparam logic [4:0] KA_OFF_CODE = 5'h00;
    localparam logic [4:0] KA_MAX_CODE = 5'h14;

    // Second status register field
    localparam int unsigned HB_STATUS_BIT = 4;

    // Pin one upper map fields
    localparam int unsigned MAP_TRIM_BIT = 7;
    localparam int unsigned MAP_CFG_BIT = 6;
    localparam int unsigned MAP_HB_BIT = 4;
    localparam int unsigned MAP_HIGH_BIT = 3;
    localparam int unsigned MAP_LOW_BIT = 2;
    localparam int unsigned MAP_DBL_BIT = 1;
    localparam int unsigned MAP_SGL_BIT = 0;
    localparam logic [7:0] MAP1_WMASK = 8'hdf;

    // Tick counter widths
    localparam int unsigned WAKE_CNT_W = 4;
    localparam int unsigned KA_CNT_W = 21;
endpackage

// >>> ktm_span_counter.sv
`timescale 1ns/10ps
module ktm_span_counter #(
    parameter int unsigned CNT_W = 4
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic tick,
    input wire logic run,
    input wire logic restart,
    input wire logic [CNT_W-1:0] limit,
    output logic expire_ff
);
    logic [CNT_W-1:0] count_ff;

    // Width check at elaboration; a one-bit count cannot hold a span
    if (CNT_W < 2)
    begin : g_bad_width
        $error("ktm_span_counter: CNT_W must be at least 2");
    end

    // Counts base ticks, one pulse when limit ticks have passed
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_ff <= '0;
            expire_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            expire_ff <= 1'b0;
            if (!run || restart)
            begin
                count_ff <= '0;
            end
            else if (tick)
            begin
                if (count_ff == (limit - CNT_W'(1)))
                begin
                    count_ff <= '0;
                    expire_ff <= 1'b1;
                end
                else
                begin
                    count_ff <= count_ff + CNT_W'(1);
                end
            end
        end
    end
endmodule // ktm_span_counter

// >>> ktm_host_model.sv
`timescale 1ns/10ps
// Host side: counts each rising edge seen on the interrupt pin
module ktm_host_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic irq_pin_one_ff,
    output logic [7:0] irq_count_ff
);
    logic last_irq_ff;

    // Edge count, not level, so a stuck pin shows as one event only
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            last_irq_ff <= 1'b0;
            irq_count_ff <= 8'h00;
        end
        else
        begin
            last_irq_ff <= irq_pin_one_ff;
            if (irq_pin_one_ff && !last_irq_ff)
                irq_count_ff <= irq_count_ff + 8'h01;
        end
    end
endmodule // ktm_host_model

// >>> test_keepalive_timer_int_map.sv
`timescale 1ns/10ps
module test_keepalive_timer_int_map;
    typedef struct {logic [7:0] map; logic [5:0] src; logic irq;} ktm_row_t;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] rdata;
    logic [5:0] src = 6'h00;
    logic [7:0] reg_rdata_ff;
    logic wake_sample_ff;
    logic heartbeat_status_ff;
    logic irq_pin_one_ff;
    logic [7:0] irq_count_ff;
    logic [7:0] cnt;
    int n_mismatch = 0;
    int tests_run = 0;
    int cyc = 0;
    int t0;
    int codes [4] = '{1, 2, 5, 12};
    int offs [3] = '{0, 21, 31};
    // Source order: trim, config, high, low, double, single
    ktm_row_t rows [10] = '{'{8'h80, 6'h20, 1'b1}, '{8'h40, 6'h10, 1'b1},
        '{8'h08, 6'h08, 1'b1}, '{8'h04, 6'h04, 1'b1}, '{8'h02, 6'h02, 1'b1},
        '{8'h01, 6'h01, 1'b1}, '{8'h5f, 6'h20, 1'b0}, '{8'h80, 6'h1f, 1'b0},
        '{8'h00, 6'h3f, 1'b0}, '{8'h20, 6'h3f, 1'b0}};

    // Short tick keeps the long spans within the run
    ktm_keepalive_timer_int_map #(.TICK_CYCLES(4)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .trim_load_error(src[5]),
        .config_error(src[4]), .aux_high(src[3]), .aux_low(src[2]),
        .double_knock(src[1]), .single_knock(src[0]), .wake_sample_ff(wake_sample_ff),
        .heartbeat_status_ff(heartbeat_status_ff), .irq_pin_one_ff(irq_pin_one_ff));
    ktm_host_model host (.ref_clk(ref_clk), .rst_n(rst_n), .irq_pin_one_ff(irq_pin_one_ff),
        .irq_count_ff(irq_count_ff));

    initial
    begin
        forever #4 ref_clk = ~ref_clk;
    end

    // Free cycle stamp for span measurement
    always @(posedge ref_clk) cyc <= cyc + 1;

    task automatic report_and_stop();
        $display("Compared %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 rdata = reg_rdata_ff;
    endtask

    // Waits at least one edge; 0 wake, 1 heartbeat, 2 pin
    task automatic wait_sig(input int w, input int lim);
        int k;
        k = 0;
        do
        begin
            @(posedge ref_clk);
            #1 k++;
        end
        while ((w == 0 ? wake_sample_ff : w == 1 ? heartbeat_status_ff : irq_pin_one_ff)
            !== 1'b1 && k < lim);
        if (k >= lim)
        begin
            n_mismatch++;
            $display("Error at %0t: wait %0d ran out, got %h expected %h", $time, w, 1'b0, 1'b1);
            report_and_stop();
        end
    endtask

    initial
    begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(8'h39);
        chk(rdata, 8'h00);
        rd(8'h3a);
        chk(rdata, 8'h00);
        rd(8'h50);
        chk(rdata, 8'h00);
        $display("reset values done");
        foreach (rows[j])
        begin
            @(posedge ref_clk) src <= rows[j].src;
            wr(8'h3a, rows[j].map);
            rd(8'h3a);
            chk(rdata, rows[j].map & 8'hdf);
            repeat (2) @(posedge ref_clk);
            #1 chk(irq_pin_one_ff, rows[j].irq);
        end
        @(posedge ref_clk) src <= 6'h00;
        $display("map rows done");
        // Second span only: the first after a write may be short
        for (int s = 0; s < 4; s++)
        begin
            wr(8'h39, 8'(s << 6));
            wait_sig(0, 200);
            t0 = cyc;
            wait_sig(0, 200);
            chk(cyc - t0, 4 << s);
        end
        $display("wake interval done");
        foreach (codes[j])
        begin
            // Clear stale status first; the first span after a write may be short
            wr(8'h39, 8'(codes[j]));
            rd(8'h0c);
            wait_sig(1, 20000);
            t0 = cyc;
            rd(8'h0c);
            wait_sig(1, 20000);
            chk(cyc - t0, 4 << codes[j]);
        end
        $display("keep-alive spans done");
        wr(8'h39, 8'h04);
        rd(8'h0c);
        wait_sig(1, 200);
        rd(8'h0c);
        chk(rdata, 8'h10);
        @(posedge ref_clk);
        #1 chk(heartbeat_status_ff, 1'b0);
        rd(8'h0c);
        chk(rdata, 8'h00);
        cnt = irq_count_ff;
        wr(8'h3a, 8'h10);
        wait_sig(2, 200);
        // Host counts the edge one clock after the pin rises
        @(posedge ref_clk);
        #1 chk(irq_count_ff, cnt + 8'h01);
        rd(8'h0c);
        repeat (2) @(posedge ref_clk);
        #1 chk(irq_pin_one_ff, 1'b0);
        $display("status clear done");
        foreach (offs[j])
        begin
            wr(8'h39, 8'(offs[j]));
            rd(8'h0c);
            repeat (150) @(posedge ref_clk);
            #1 chk(heartbeat_status_ff, 1'b0);
        end
        $display("timer off done");
        wr(8'h39, 8'hff);
        rd(8'h39);
        chk(rdata, 8'hff);
        // Frozen clock enable must drop the write
        @(posedge ref_clk) clk_en <= 1'b0;
        wr(8'h39, 8'h41);
        @(posedge ref_clk) clk_en <= 1'b1;
        rd(8'h39);
        chk(rdata, 8'hff);
        @(posedge ref_clk) rst_n <= 1'b0;
        @(posedge ref_clk);
        #1 chk({reg_rdata_ff, heartbeat_status_ff, irq_pin_one_ff}, 10'h000);
        @(posedge ref_clk) rst_n <= 1'b1;
        rd(8'h39);
        chk(rdata, 8'h00);
        rd(8'h3a);
        chk(rdata, 8'h00);
        $display("mid-run reset done");
        report_and_stop();
    end
endmodule // test_keepalive_timer_int_map
